//--- ioc_pkg.sv
// Purpose: Shared constants for the interleave offset corrector
// Assumes: Byte-wide register port with 16-bit addresses
// Notes: Control codes select run, freeze or bypass per channel
package ioc_pkg;
   localparam logic [15:0] IOC_ADDR_PAGE0 = 16'h4001;
   localparam logic [15:0] IOC_ADDR_PAGE1 = 16'h4002;
   localparam logic [15:0] IOC_ADDR_PAGE_CH = 16'h4003;
   localparam logic [15:0] IOC_ADDR_PAGE_BLK = 16'h4004;
   localparam logic [15:0] IOC_ADDR_CTRL = 16'h6068;
   localparam logic [7:0] IOC_PAGE_BLK_CORR = 8'h61;
   localparam logic [7:0] IOC_PAGE_CH_A = 8'h00;
   localparam logic [7:0] IOC_PAGE_CH_B = 8'h01;
   localparam logic [7:0] IOC_CTRL_FREEZE = 8'hC2;
   localparam logic [7:0] IOC_CTRL_BYPASS = 8'h46;
   localparam logic [7:0] IOC_CTRL_RESET = 8'h00;
   localparam logic [7:0] IOC_REG_RESET = 8'h00;
   localparam int IOC_NUM_CORES = 4;
   localparam int IOC_CLK_PERIOD_NS = 10;
   localparam int IOC_MIN_EST_TIME_US = 400; // 0.4 ms
   localparam int IOC_MIN_EST_CYCLES = (IOC_MIN_EST_TIME_US * 1000 + IOC_CLK_PERIOD_NS - 1) / IOC_CLK_PERIOD_NS;
   typedef enum logic [1:0] {IOC_RUN, IOC_FREEZE, IOC_BYPASS} ioc_mode_t;
endpackage : ioc_pkg

//--- ioc_cfg_if.sv
// Purpose: Carries mode from the register block to one channel corrector
// Assumes: Single clock domain
// Notes: Register side drives, corrector side listens
`timescale 1ns/100ps
interface ioc_cfg_if;
   import ioc_pkg::*;
   ioc_mode_t mode;
   modport regs (output mode);
   modport corr (input mode);
endinterface : ioc_cfg_if

//--- ioc_corrector.sv
// Purpose: One channel offset estimator and canceller over four cores
// Assumes: Samples arrive round-robin over cores, slot index given
// Notes: Per-core mean by leaky integrator; subtracting it cancels nfs/4 tones
`timescale 1ns/100ps
module ioc_corrector
   import ioc_pkg::*;
#(
   parameter int DW = 14,
   parameter int SHIFT = 10
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Mode
   ioc_cfg_if.corr cfg,
   // Sample stream
   input wire logic smp_valid_i,
   input wire logic [1:0] smp_core_i,
   input wire logic signed [DW-1:0] smp_data_i,
   output logic smp_valid_o,
   output logic signed [DW-1:0] smp_data_o
);
   localparam int AW = DW + SHIFT;
   logic signed [AW-1:0] acc_q [IOC_NUM_CORES];

   function automatic logic signed [DW-1:0] est_of(input logic signed [AW-1:0] a);
      est_of = DW'(a >>> SHIFT);
   endfunction : est_of

   ////////////////////////////////////////////////////////////////////////////
   // Estimate update: only while running; freeze holds, bypass holds too
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < IOC_NUM_CORES; i++) begin
            acc_q[i] <= '0;
         end
      end else if (smp_valid_i && cfg.mode == IOC_RUN) begin
         // Tones at these bins are absorbed whatever their origin
         acc_q[smp_core_i] <= acc_q[smp_core_i] + AW'(smp_data_i) - AW'(est_of(acc_q[smp_core_i]));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output: subtract per-core estimate unless bypassed
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         smp_valid_o <= 1'b0;
         smp_data_o <= '0;
      end else begin
         smp_valid_o <= smp_valid_i;
         if (cfg.mode == IOC_BYPASS) begin
            smp_data_o <= smp_data_i;
         end else begin
            smp_data_o <= smp_data_i - est_of(acc_q[smp_core_i]);
         end
      end
   end
endmodule : ioc_corrector

//--- ioc_top.sv
// Purpose: Two-channel interleave offset corrector with paged registers
// Assumes: Register port is a byte write/read strobe interface, synchronous
// Notes: Any control value other than freeze or bypass runs the corrector
//        A control write on a closed page, or with an unknown channel byte, is dropped
//        Freeze and bypass both hold the estimate, so a return to run resumes from it
//        Ready status only reports elapsed run time; it cannot stop an early freeze
//        Read data is registered and stands until the next read strobe
//        Page bytes and control bytes reset to zero, so the corrector page starts closed
`timescale 1ns/100ps
module ioc_top
   import ioc_pkg::*;
#(
   parameter int DW = 14,
   parameter int SHIFT = 10
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Channel A samples
   input wire logic a_valid_i,
   input wire logic [1:0] a_core_i,
   input wire logic signed [DW-1:0] a_data_i,
   output logic a_valid_o,
   output logic signed [DW-1:0] a_data_o,
   // Channel B samples
   input wire logic b_valid_i,
   input wire logic [1:0] b_core_i,
   input wire logic signed [DW-1:0] b_data_i,
   output logic b_valid_o,
   output logic signed [DW-1:0] b_data_o,
   // Status
   output logic [1:0] est_ready_o
);
   // Page bytes, held until rewritten
   logic [7:0] page0_q, page1_q, page_ch_q, page_blk_q;
   // Control byte of each channel
   logic [7:0] ctrl_a_q, ctrl_b_q;
   // Page decode and steered control strobes
   logic corr_page_ok, sel_a, sel_b;
   logic wr_ctrl_a, wr_ctrl_b;
   // Run-time counters and the registered ready flags
   logic [31:0] run_cnt_a_q, run_cnt_b_q;
   logic [31:0] run_cnt_a_d, run_cnt_b_d;
   logic [1:0] est_ready_q;

   ioc_cfg_if cfg_a ();
   ioc_cfg_if cfg_b ();

   function automatic ioc_mode_t mode_of(input logic [7:0] v);
      case (v)
         IOC_CTRL_FREEZE: mode_of = IOC_FREEZE;
         IOC_CTRL_BYPASS: mode_of = IOC_BYPASS;
         default: mode_of = IOC_RUN;
      endcase
   endfunction : mode_of

   // Next run count: cleared outside run mode, saturating at the minimum estimation count
   function automatic logic [31:0] next_run(input ioc_mode_t m, input logic [31:0] c);
      if (m != IOC_RUN) begin
         next_run = '0;
      end else if (c < 32'(IOC_MIN_EST_CYCLES)) begin
         next_run = c + 32'h1;
      end else begin
         next_run = c;
      end
   endfunction : next_run

   // Control read-back follows the open page; a closed page or unknown channel reads zero
   function automatic logic [7:0] ctrl_view(input logic ok, input logic sa, input logic sb,
                                            input logic [7:0] ca, input logic [7:0] cb);
      if (!ok) begin
         ctrl_view = IOC_REG_RESET;
      end else if (sb) begin
         ctrl_view = cb;
      end else if (sa) begin
         ctrl_view = ca;
      end else begin
         ctrl_view = IOC_REG_RESET;
      end
   endfunction : ctrl_view

   ////////////////////////////////////////////////////////////////////////////
   // Page decode: the corrector page is open while both page bytes are zero and the block byte selects the corrector
   assign corr_page_ok = page0_q == IOC_REG_RESET && page1_q == IOC_REG_RESET &&
                         page_blk_q == IOC_PAGE_BLK_CORR;
   assign sel_b = page_ch_q == IOC_PAGE_CH_B;
   assign sel_a = page_ch_q == IOC_PAGE_CH_A;

   // Control strobes: any other channel byte drops the write, so no channel is hit by mistake
   assign wr_ctrl_a = reg_wr_i && reg_addr_i == IOC_ADDR_CTRL && corr_page_ok && sel_a;
   assign wr_ctrl_b = reg_wr_i && reg_addr_i == IOC_ADDR_CTRL && corr_page_ok && sel_b;

   // Page registers hold until rewritten
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         page0_q <= IOC_REG_RESET;
         page1_q <= IOC_REG_RESET;
         page_ch_q <= IOC_REG_RESET;
         page_blk_q <= IOC_REG_RESET;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            IOC_ADDR_PAGE0: page0_q <= reg_wdata_i;
            IOC_ADDR_PAGE1: page1_q <= reg_wdata_i;
            IOC_ADDR_PAGE_CH: page_ch_q <= reg_wdata_i;
            IOC_ADDR_PAGE_BLK: page_blk_q <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control writes land in the channel of the current page only
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_a_q <= IOC_CTRL_RESET;
      end else if (wr_ctrl_a) begin
         ctrl_a_q <= reg_wdata_i;
      end
   end

   // Channel B control byte, same rules as channel A
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_b_q <= IOC_CTRL_RESET;
      end else if (wr_ctrl_b) begin
         ctrl_b_q <= reg_wdata_i;
      end
   end

   assign cfg_a.mode = mode_of(ctrl_a_q);
   assign cfg_b.mode = mode_of(ctrl_b_q);

   ////////////////////////////////////////////////////////////////////////////
   // Read-back: unmapped or off-page addresses read zero
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= IOC_REG_RESET;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            IOC_ADDR_PAGE0: reg_rdata_o <= page0_q;
            IOC_ADDR_PAGE1: reg_rdata_o <= page1_q;
            IOC_ADDR_PAGE_CH: reg_rdata_o <= page_ch_q;
            IOC_ADDR_PAGE_BLK: reg_rdata_o <= page_blk_q;
            IOC_ADDR_CTRL: reg_rdata_o <= ctrl_view(corr_page_ok, sel_a, sel_b, ctrl_a_q, ctrl_b_q);
            default: reg_rdata_o <= IOC_REG_RESET;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Run-time counters: flag when the minimum estimation time has elapsed.
   // Freezing earlier is the host's mistake; the flag only lets it check.
   assign run_cnt_a_d = next_run(cfg_a.mode, run_cnt_a_q);
   assign run_cnt_b_d = next_run(cfg_b.mode, run_cnt_b_q);

   // Channel A run time
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_cnt_a_q <= '0;
      end else begin
         run_cnt_a_q <= run_cnt_a_d;
      end
   end

   // Channel B run time
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_cnt_b_q <= '0;
      end else begin
         run_cnt_b_q <= run_cnt_b_d;
      end
   end

   // Ready flags come from the next count, so they track the counters edge for edge
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         est_ready_q <= 2'h0;
      end else begin
         est_ready_q[0] <= run_cnt_a_d == 32'(IOC_MIN_EST_CYCLES);
         est_ready_q[1] <= run_cnt_b_d == 32'(IOC_MIN_EST_CYCLES);
      end
   end

   assign est_ready_o = est_ready_q;

   ////////////////////////////////////////////////////////////////////////////
   // One corrector per channel
   ioc_corrector #(.DW(DW), .SHIFT(SHIFT)) u_corr_a (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .cfg(cfg_a.corr),
      .smp_valid_i(a_valid_i),
      .smp_core_i(a_core_i),
      .smp_data_i(a_data_i),
      .smp_valid_o(a_valid_o),
      .smp_data_o(a_data_o)
   );

   ioc_corrector #(.DW(DW), .SHIFT(SHIFT)) u_corr_b (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .cfg(cfg_b.corr),
      .smp_valid_i(b_valid_i),
      .smp_core_i(b_core_i),
      .smp_data_i(b_data_i),
      .smp_valid_o(b_valid_o),
      .smp_data_o(b_data_o)
   );
endmodule : ioc_top

//--- ioc_top_sva.sv
// Purpose: Port assertions for the offset corrector top
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Page registers and channel A bypass are shadowed from writes
`timescale 1ns/100ps
module ioc_top_sva
   import ioc_pkg::*;
#(
   parameter int DW = 14
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Samples and status
   input wire logic a_valid_i,
   input wire logic signed [DW-1:0] a_data_i,
   input wire logic a_valid_o,
   input wire logic signed [DW-1:0] a_data_o,
   input wire logic b_valid_i,
   input wire logic b_valid_o,
   input wire logic [1:0] est_ready_o
);
   logic [3:0][7:0] pg_q;
   logic a_byp_q;
   logic pg_wr;
   logic ctl_a;
   assign pg_wr = reg_wr_i && (reg_addr_i - IOC_ADDR_PAGE0) < 16'h0004;
   assign ctl_a = reg_wr_i && reg_addr_i == IOC_ADDR_CTRL && pg_q == {IOC_PAGE_BLK_CORR, IOC_PAGE_CH_A, 16'h0000};
   ////////////////////////////////////////////////////////////////
   // Page shadow, so refused control writes are not mistaken for mode changes
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) pg_q <= '0;
      else if (pg_wr) pg_q[2'(reg_addr_i - IOC_ADDR_PAGE0)] <= reg_wdata_i;
   end
   // Channel A bypass shadow
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) a_byp_q <= 1'b0;
      else if (ctl_a) a_byp_q <= reg_wdata_i == IOC_CTRL_BYPASS;
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_pg_write;
      pg_wr;
   endsequence
   sequence s_same_read;
      reg_rd_i && reg_addr_i == $past(reg_addr_i, 2);
   endsequence
   a_valid_a_delay:
      assert property (1'b1 |=> a_valid_o == $past(a_valid_i)) else $error("channel A valid not delayed");
   a_valid_b_delay:
      assert property (1'b1 |=> b_valid_o == $past(b_valid_i)) else $error("channel B valid not delayed");
   a_bypass_pass:
      assert property (a_byp_q && a_valid_i |=> a_data_o == $past(a_data_i)) else $error("bypass altered data");
   a_rdata_hold:
      assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved without a read");
   a_unmapped_zero:
      assert property (reg_rd_i && !((reg_addr_i - IOC_ADDR_PAGE0) < 16'h0004) && reg_addr_i != IOC_ADDR_CTRL
         |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   a_page_readback:
      assert property (s_pg_write ##2 s_same_read |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("page readback");
   a_closed_ctrl:
      assert property (reg_rd_i && reg_addr_i == IOC_ADDR_CTRL && pg_q[3] != IOC_PAGE_BLK_CORR
         |=> reg_rdata_o == 8'h00) else $error("closed page control read not zero");
   a_freeze_status:
      assert property (ctl_a && reg_wdata_i == IOC_CTRL_FREEZE |-> ##[1:2] !est_ready_o[0]) else $error("ready after freeze");
endmodule : ioc_top_sva

//--- ioc_host_model.sv
// Purpose: Host that writes and reads the corrector registers
// Assumes: Strobe is taken on the rising edge it is high at
// Notes: Each access takes two cycles so a strobe never toggles twice in one step
`timescale 1ns/100ps
module ioc_host_model
   import ioc_pkg::*;
(
   // Bus
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic wr_o = 1'b0,
   output logic rd_o = 1'b0,
   output logic [15:0] addr_o = 16'h0000,
   output logic [7:0] wdata_o = 8'h00
);
   ////////////////////////////////////////////////////////////////
   // Byte write
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge clk_i);
      #1 wr_o = 1'b0;
      @(posedge clk_i);
      #1;
   endtask : wr
   // Byte read, data registered at the taking edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clk_i);
      #1 rd_o = 1'b0;
      d = rdata_i;
      @(posedge clk_i);
      #1;
   endtask : rd
   // Open the corrector page of one channel; caller idles input long enough first
   task automatic page(input logic [7:0] ch);
      wr(IOC_ADDR_PAGE0, 8'h00);
      wr(IOC_ADDR_PAGE1, 8'h00);
      wr(IOC_ADDR_PAGE_CH, ch);
      wr(IOC_ADDR_PAGE_BLK, IOC_PAGE_BLK_CORR);
   endtask : page
endmodule : ioc_host_model

//--- ioc_top_tb_top.sv
// Purpose: Self-checking bench for the offset corrector top
// Assumes: SHIFT of 2 keeps the estimator fast in simulation
// Notes: Model keeps per-core leaky means and a mode per channel
`timescale 1ns/100ps
module ioc_top_tb_top;
   import ioc_pkg::*;
   localparam int DW = 14;
   localparam int SH = 2;
   logic core_clk_i = 0, rst_n_i = 0, a_valid_i = 0, b_valid_i = 0, a_valid_o, b_valid_o;
   logic reg_wr_i, reg_rd_i;
   logic [15:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, rd, r = 8'h17;
   logic [1:0] a_core_i = 0, b_core_i = 0, est_ready_o;
   logic signed [DW-1:0] a_data_i = 0, b_data_i = 0, a_data_o, b_data_o;
   logic [15:0] ad [5] = '{IOC_ADDR_PAGE0, IOC_ADDR_PAGE1, IOC_ADDR_PAGE_CH, IOC_ADDR_PAGE_BLK, IOC_ADDR_CTRL};
   int acc [2][4], mode [2], n_mismatch = 0, compares = 0;
   always #5 core_clk_i = ~core_clk_i;
   ioc_host_model host (.clk_i(core_clk_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
      .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
   ioc_top #(.DW(DW), .SHIFT(SH)) uut (.core_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
      .reg_rdata_o, .a_valid_i, .a_core_i, .a_data_i, .a_valid_o, .a_data_o, .b_valid_i, .b_core_i, .b_data_i,
      .b_valid_o, .b_data_o, .est_ready_o);
   ////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (e !== g) begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", n, e, g);
      end
   endtask : chk
   // Samples on both channels, cores in turn; mode 0 run, 1 freeze, 2 bypass
   task automatic burst(input int n);
      int x [2], e [2];
      for (int i = 0; i < n; i++) begin
         for (int c = 0; c < 2; c++) begin
            r = lfsr(r);
            x[c] = (c ? -25 : 30) * (i % 4 - 1) + int'(r[2:0]);
            e[c] = mode[c] == 2 ? x[c] : x[c] - (acc[c][i % 4] >>> SH);
            if (mode[c] == 0) acc[c][i % 4] += x[c] - (acc[c][i % 4] >>> SH);
         end
         {a_core_i, b_core_i, a_data_i, b_data_i} = {2'(i), 2'(i), DW'(x[0]), DW'(x[1])};
         {a_valid_i, b_valid_i} = 2'b11;
         @(posedge core_clk_i);
         #1 chk("a_data", 32'(e[0]), 32'(a_data_o));
         chk("b_data", 32'(e[1]), 32'(b_data_o));
         chk("valid", 32'h3, 32'({a_valid_o, b_valid_o}));
      end
      {a_valid_i, b_valid_i} = 2'b00;
      @(posedge core_clk_i);
      #1 chk("valid", 32'h0, 32'({a_valid_o, b_valid_o}));
   endtask : burst
   task automatic final_report;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////
   // Watchdog well past the long idle estimation wait
   initial begin
      #600000 n_mismatch++;
      final_report;
   end
   initial begin
      repeat (3) @(posedge core_clk_i);
      #1 rst_n_i = 1;
      foreach (ad[i]) begin
         host.rd(ad[i], rd);
         chk("reset reg", IOC_REG_RESET, rd);
      end
      host.rd(16'h1234, rd);
      chk("unmapped", 8'h00, rd);
      host.wr(IOC_ADDR_CTRL, IOC_CTRL_FREEZE);
      host.rd(IOC_ADDR_CTRL, rd);
      chk("closed ctrl", 8'h00, rd);
      burst(40);
      repeat (IOC_MIN_EST_CYCLES) @(posedge core_clk_i);
      #1 chk("ready", 2'b11, est_ready_o);
      host.page(IOC_PAGE_CH_A);
      host.wr(IOC_ADDR_CTRL, IOC_CTRL_FREEZE);
      mode[0] = 1;
      host.rd(IOC_ADDR_CTRL, rd);
      chk("ctrl A", IOC_CTRL_FREEZE, rd);
      host.wr(IOC_ADDR_PAGE_CH, IOC_PAGE_CH_B);
      host.rd(IOC_ADDR_PAGE_CH, rd);
      chk("page ch", IOC_PAGE_CH_B, rd);
      host.wr(IOC_ADDR_CTRL, IOC_CTRL_FREEZE);
      mode[1] = 1;
      chk("frozen ready", 2'b00, est_ready_o);
      // Input comes back only now that both channels hold their estimate
      burst(12);
      host.wr(IOC_ADDR_CTRL, IOC_CTRL_BYPASS);
      mode[1] = 2;
      burst(8);
      host.wr(IOC_ADDR_PAGE_CH, IOC_PAGE_CH_A);
      host.wr(IOC_ADDR_CTRL, IOC_CTRL_BYPASS);
      mode[0] = 2;
      host.rd(IOC_ADDR_CTRL, rd);
      chk("ctrl A", IOC_CTRL_BYPASS, rd);
      burst(8);
      host.wr(IOC_ADDR_CTRL, IOC_CTRL_RESET);
      mode[0] = 0;
      burst(8);
      final_report;
   end
endmodule : ioc_top_tb_top
bind ioc_top ioc_top_sva #(.DW(DW)) u_sva (.core_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
   .reg_wdata_i, .reg_rdata_o, .a_valid_i, .a_data_i, .a_valid_o, .a_data_o, .b_valid_i, .b_valid_o, .est_ready_o);
